/* File: bench/idsn_asserts.sv */
module idsn_asserts (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic scl,
	input  wire logic host_sda_o,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_o,
	input  wire logic dev_sda_oe,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] lo_cnt_r;
	logic [7:0] hi_cnt_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// saturating so a stalled bus cannot wrap the count back into range
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lo_cnt_r <= 4'h0;
		else if (scl)
			lo_cnt_r <= 4'h0;
		else if (lo_cnt_r != 4'hf)
			lo_cnt_r <= lo_cnt_r + 4'h1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hi_cnt_r <= 8'h0;
		else if (!scl)
			hi_cnt_r <= 8'h0;
		else if (hi_cnt_r != 8'hff)
			hi_cnt_r <= hi_cnt_r + 8'h1;
	end

	dev_drive_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed sda while scl high");
	dev_drive_late_a: assert property ($changed(dev_sda_oe) |-> lo_cnt_r <= 4'h9)
		else $error("device sda change too late after scl fall");
	dev_idle_quiet_a: assert property (hi_cnt_r > 8'h1e |-> !dev_sda_oe)
		else $error("device drives sda on an idle bus");
	start_quiet_a: assert property (scl && $fell(sda) |-> !dev_sda_oe [*8])
		else $error("device drives sda right after a start");
	scl_high_len_a: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high phase too short");
	scl_low_len_a: assert property ($fell(scl) |-> !scl [*4])
		else $error("scl low phase too short");
	reset_rest_a: assert property ($rose(rst_n_i) |-> scl && !host_sda_oe && !dev_sda_oe)
		else $error("bus not at rest after reset");
	open_drain_a: assert property (!host_sda_o && !dev_sda_o && !(host_sda_oe && dev_sda_oe))
		else $error("sda driven high or pulled by both ends");

	cover property (scl && $fell(sda) ##[1:300] $rose(dev_sda_oe));
endmodule : idsn_asserts

/* File: bench/idsn_test.sv */
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %h got %h", nm, e, a); end end

module idsn_test;
	import idsn_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// arbitrary value
	localparam logic [127:0] SN  = 128'h5aa5c33c96693cc3f00f1ee1a55a7887;
	localparam logic [2:0]   DEV = 3'h2;

	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       cmd_valid_i = 1'b0;
	logic       cmd_ready_o;
	idsn_op_t   cmd_op_i = OP_MAIN_READ;
	logic [2:0] cmd_dev_i = 3'h0;
	logic [15:0] cmd_addr_i = 16'h0;
	logic [7:0] cmd_len_i = 8'h0;
	logic [7:0] cmd_wdata_i = 8'h0;
	logic       rd_valid_o;
	logic       rd_ready_i = 1'b0;
	logic [7:0] rd_data_o;
	logic       done_o;
	logic       nack_o;
	logic       id_locked_o;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         cyc = 0;
	logic [7:0] idm [0:31];
	logic [7:0] exp_q [$];
	logic [7:0] got_q [$];
	int         ofs_l [6] = '{0, 3, 4, 5, 30, 31};

	idsn_if link ();

	idsn_host #(.QTR(SCL_QTR_CYC), .DEPTH(2)) u_idsn_host (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.bus        (link),
		.cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o),
		.cmd_op_i   (cmd_op_i),
		.cmd_dev_i  (cmd_dev_i),
		.cmd_addr_i (cmd_addr_i),
		.cmd_len_i  (cmd_len_i),
		.cmd_wdata_i(cmd_wdata_i),
		.rd_valid_o (rd_valid_o),
		.rd_ready_i (rd_ready_i),
		.rd_data_o  (rd_data_o),
		.done_o     (done_o),
		.nack_o     (nack_o)
	);

	idsn_dev #(.SERIAL(SN)) u_idsn_dev (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.bus        (link),
		.strap_i    (DEV),
		.id_locked_o(id_locked_o)
	);

	idsn_asserts u_idsn_asserts (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.scl        (link.scl),
		.host_sda_o (link.host_sda_o),
		.host_sda_oe(link.host_sda_oe),
		.dev_sda_o  (link.dev_sda_o),
		.dev_sda_oe (link.dev_sda_oe),
		.sda        (link.sda)
	);

	always #4 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ready only a quarter of the time, so the two-entry buffer fills and the host stalls
	always @(negedge clk_i) rd_ready_i <= (cyc[9:8] == 2'h0);

	always @(posedge clk_i) begin
		if (rst_n_i && rd_valid_o === 1'b1 && rd_ready_i)
			got_q.push_back(rd_data_o);
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic run(input idsn_op_t op, input logic [2:0] dev, input logic [15:0] addr,
			input logic [7:0] len, input logic [7:0] wd, input logic exp_nack);
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		cmd_op_i = op;
		cmd_dev_i = dev;
		cmd_addr_i = addr;
		cmd_len_i = len;
		cmd_wdata_i = wd;
		cmd_valid_i = 1'b1;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 20000) begin
			@(negedge clk_i);
			n++;
		end
		`CHK("done", 1'b1, done_o)
		`CHK("nack", exp_nack, nack_o)
		n = 0;
		while (got_q.size() < exp_q.size() && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		repeat (4) @(negedge clk_i);
		foreach (exp_q[k]) `CHK("rd_data", exp_q[k], got_q[k])
		`CHK("rd_count", exp_q.size(), got_q.size())
		exp_q = {};
		got_q = {};
	endtask : run

	initial begin
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
		`CHK("lock_rst", 1'b0, id_locked_o)
		foreach (ofs_l[i]) begin
			idm[ofs_l[i]] = 8'h3c + 8'(ofs_l[i] * 7);
			run(OP_PROBE, DEV, 16'(ofs_l[i]), 8'h1, idm[ofs_l[i]], 1'b0);
		end
		exp_q = '{idm[3], idm[4]};
		run(OP_ID_READ, DEV, 16'h0003, 8'h2, 8'h0, 1'b0);
		exp_q = '{idm[5]};
		run(OP_CUR_SPEC, DEV, 16'h0, 8'h1, 8'h0, 1'b0);
		exp_q = '{idm[30], idm[31]};
		run(OP_ID_READ, DEV, 16'h001e, 8'h5, 8'h0, 1'b0);
		exp_q = '{idm[0]};
		run(OP_CUR_SPEC, DEV, 16'h0, 8'h1, 8'h0, 1'b0);
		for (int i = 0; i < SN_BYTES; i++)
			exp_q.push_back(SN[127 - 8 * i -: 8]);
		run(OP_SN_READ, DEV, 16'h0, 8'h10, 8'h0, 1'b0);
		run(OP_ID_READ, 3'h5, 16'h0, 8'h1, 8'h0, 1'b1);
		run(OP_PROBE, DEV, 16'h0400, 8'h1, 8'h02, 1'b0);
		`CHK("locked", 1'b1, id_locked_o)
		// the lock write leaves the pointer in region 01, which reads undefined
		exp_q = '{UNDEF_BYTE};
		run(OP_CUR_SPEC, DEV, 16'h0, 8'h1, 8'h0, 1'b0);
		run(OP_PROBE, DEV, 16'h0003, 8'h1, 8'h00, 1'b1);
		exp_q = '{idm[3]};
		run(OP_ID_READ, DEV, 16'h0003, 8'h1, 8'h0, 1'b0);
		end_sim();
	end
endmodule : idsn_test

/* File: include/idsn_if.sv */
interface idsn_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// open-drain wired-and with pull-up
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output scl, host_sda_o, host_sda_oe, input sda);
	modport dev (input scl, sda, output dev_sda_o, dev_sda_oe);
endinterface : idsn_if

/* File: include/idsn_pkg.sv */
package idsn_pkg;
	localparam int          ADDR_W        = 13;
	localparam int          BYTE_W        = 8;
	localparam int          ID_BYTES      = 32;
	localparam int          ID_OFS_W      = 5;
	localparam int          SN_BYTES      = 16;
	localparam int          SN_OFS_W      = 4;
	localparam int          REG_LSB       = 10;
	localparam int          LOCK_POS      = 10;
	localparam int          LOCK_DATA_POS = 1;
	localparam logic [1:0]  REGION_ID     = 2'h0;
	localparam logic [1:0]  REGION_SN     = 2'h2;
	localparam logic [3:0]  DT_MAIN       = 4'ha;
	// special-area select code: arbitrary value
	localparam logic [3:0]  DT_SPECIAL    = 4'h5;
	localparam logic [7:0]  UNDEF_BYTE    = 8'hff;
	localparam logic [15:0] SN_START_ADDR = 16'h0800;
	localparam logic [15:0] ID_OFS_MASK   = 16'h001f;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	// synchroniser rest value: straps low, scl and sda high
	localparam logic [4:0]  PIN_REST      = 5'h03;
	localparam int          SCL_QTR_CYC   = 5;

	typedef enum logic [2:0] {
		OP_MAIN_READ = 3'h0,
		OP_ID_READ   = 3'h1,
		OP_SN_READ   = 3'h2,
		OP_PROBE     = 3'h3,
		OP_CUR_MAIN  = 3'h4,
		OP_CUR_SPEC  = 3'h5
	} idsn_op_t;
endpackage : idsn_pkg

/* File: src/idsn_buf2.sv */
module idsn_buf2 #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready_o  = cnt_r != (PW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o  = mem_r[rp_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : idsn_buf2

/* File: src/idsn_dev.sv */
// Function
// RULE1 - ID page read framed like main read
// RULE2 - ID region pair zero, five-bit offset
// RULE3 - master stays within page end
// RULE4 - probe is write with one data byte
// RULE5 - probe acked when unlocked, released when locked
// RULE6 - serial read: dummy write, restart, read
// RULE7 - master reads all 128 bits from start
// RULE8 - one pointer shared, current read continues
// RULE9 - master does dummy write before serial read
// RULE10 - serial needs region pair one-zero
// RULE11 - master ends read with nack, stop
// RULE12 - master ack advances pointer, next byte
// RULE13 - locked page refuses ID data bytes
// RULE14 - ack matching select, else standby
// RULE15 - ID read wraps within page
module idsn_dev
	import idsn_pkg::*;
#(
	// arbitrary value
	parameter logic [127:0] SERIAL = 128'h0123456789abcdef0f1e2d3c4b5a6978
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	idsn_if.dev             bus,
	input  wire logic [2:0] strap_i,
	output logic            id_locked_o
);
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX   = 5'h02,
		D_ACK  = 5'h04,
		D_TX   = 5'h08,
		D_RACK = 5'h10
	} idsn_dst_t;

	typedef enum logic [3:0] {
		P_DEV  = 4'h1,
		P_AHI  = 4'h2,
		P_ALO  = 4'h4,
		P_DATA = 4'h8
	} idsn_dph_t;

	idsn_dst_t           st_r;
	idsn_dph_t           ph_r;
	logic [4:0]          s1_r;
	logic [4:0]          s2_r;
	logic [4:0]          s3_r;
	logic [4:0]          pin_r;
	logic [4:0]          pin_d_r;
	logic [3:0]          bitc_r;
	logic [7:0]          sh_r;
	logic [7:0]          tx_r;
	logic [ADDR_W-1:0]   ptr_r;
	logic                spec_r;
	logic                rd_r;
	logic                mack_r;
	logic                oe_r;
	logic                locked_r;
	logic [7:0]          main_mem [2**ADDR_W];
	logic [7:0]          id_mem [ID_BYTES];
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;
	logic                rx_done;
	logic                wr_ev;
	logic                load_ev;
	logic                dev_hit;
	logic                data_ok;
	logic                byte_ack;
	logic [1:0]          region;
	logic [SN_OFS_W-1:0] sn_idx;
	logic [7:0]          rd_byte;
	logic [ADDR_W-1:0]   rd_inc;
	logic [ADDR_W-1:0]   wr_inc;

	// bit layout: straps, scl, sda; the straps are pins too and share the path
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r    <= PIN_REST;
			s2_r    <= PIN_REST;
			s3_r    <= PIN_REST;
			pin_r   <= PIN_REST;
			pin_d_r <= PIN_REST;
		end else begin
			s1_r    <= {strap_i, bus.scl, bus.sda};
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			pin_r   <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
			pin_d_r <= pin_r;
		end
	end

	assign scl_rise  = pin_r[1] & ~pin_d_r[1];
	assign scl_fall  = ~pin_r[1] & pin_d_r[1];
	assign bus_start = pin_r[1] & pin_d_r[1] & pin_d_r[0] & ~pin_r[0];
	assign bus_stop  = pin_r[1] & pin_d_r[1] & ~pin_d_r[0] & pin_r[0];
	assign rx_done   = (st_r == D_RX) & scl_fall & (bitc_r == BYTE_BITS);
	assign wr_ev     = rx_done & byte_ack & (ph_r == P_DATA) & ~rd_r;
	assign load_ev   = scl_fall & (((st_r == D_ACK) & rd_r) | ((st_r == D_RACK) & mack_r));
	assign region    = ptr_r[REG_LSB+1:REG_LSB];

	assign dev_hit = ((sh_r[7:4] == DT_MAIN) | (sh_r[7:4] == DT_SPECIAL)) // RULE1
		& (sh_r[3:1] == pin_r[4:2]); // RULE14

	// lock command and ID data are refused once locked; serial area is read-only
	assign data_ok = ~spec_r | (~locked_r & (ptr_r[LOCK_POS] | (region == REGION_ID))); // RULE13 RULE5

	always_comb begin
		case (ph_r)
			P_DEV:   byte_ack = dev_hit; // RULE14
			P_AHI:   byte_ack = 1'b1;
			P_ALO:   byte_ack = 1'b1;
			P_DATA:  byte_ack = data_ok; // RULE5
			default: byte_ack = 1'b0;
		endcase
	end

	// serial byte 0 is the most significant byte; 15 - n is the bitwise inverse
	assign sn_idx = ~ptr_r[SN_OFS_W-1:0];

	always_comb begin
		rd_byte = UNDEF_BYTE; // RULE10
		if (!spec_r) begin
			rd_byte = main_mem[ptr_r];
		end else if (region == REGION_ID) begin
			rd_byte = id_mem[ptr_r[ID_OFS_W-1:0]]; // RULE2
		end else if (region == REGION_SN) begin
			rd_byte = SERIAL[{sn_idx, 3'h0} +: 8]; // RULE10
		end
	end

	always_comb begin
		rd_inc = ptr_r + 1'b1;
		if (spec_r && region == REGION_SN) begin
			rd_inc = {ptr_r[ADDR_W-1:SN_OFS_W], ptr_r[SN_OFS_W-1:0] + 1'b1};
		end else if (spec_r) begin
			rd_inc = {ptr_r[ADDR_W-1:ID_OFS_W], ptr_r[ID_OFS_W-1:0] + 1'b1}; // RULE15
		end
	end

	assign wr_inc = {ptr_r[ADDR_W-1:ID_OFS_W], ptr_r[ID_OFS_W-1:0] + 1'b1};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r   <= D_IDLE;
			bitc_r <= '0;
			sh_r   <= '0;
			tx_r   <= '0;
			oe_r   <= 1'b0;
			mack_r <= 1'b0;
		end else if (bus_start) begin
			st_r   <= D_RX;
			bitc_r <= '0;
			oe_r   <= 1'b0;
		end else if (bus_stop) begin
			st_r <= D_IDLE;
			oe_r <= 1'b0;
		end else begin
			case (st_r)
				D_RX: begin
					if (scl_rise) begin
						sh_r   <= {sh_r[6:0], pin_r[0]};
						bitc_r <= bitc_r + 1'b1;
					end else if (rx_done) begin
						// a refused byte leaves the slot released and drops to standby
						st_r   <= byte_ack ? D_ACK : D_IDLE; // RULE14 RULE13
						oe_r   <= byte_ack; // RULE5
						bitc_r <= '0;
					end
				end
				D_ACK: begin
					if (load_ev) begin
						st_r <= D_TX;
						tx_r <= rd_byte;
						oe_r <= ~rd_byte[7];
					end else if (scl_fall) begin
						st_r <= D_RX;
						oe_r <= 1'b0;
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (bitc_r == LAST_BIT) begin
							st_r <= D_RACK;
							oe_r <= 1'b0;
						end else begin
							bitc_r <= bitc_r + 1'b1;
							tx_r   <= {tx_r[6:0], 1'b0};
							oe_r   <= ~tx_r[6];
						end
					end
				end
				D_RACK: begin
					if (scl_rise) begin
						mack_r <= ~pin_r[0];
					end else if (load_ev) begin
						st_r   <= D_TX; // RULE12
						bitc_r <= '0;
						tx_r   <= rd_byte;
						oe_r   <= ~rd_byte[7];
					end else if (scl_fall) begin
						st_r <= D_IDLE;
					end
				end
				default: st_r <= D_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ph_r   <= P_DEV;
			rd_r   <= 1'b0;
			spec_r <= 1'b0;
		end else if (bus_start) begin
			ph_r <= P_DEV;
			rd_r <= 1'b0;
		end else if (rx_done && byte_ack) begin
			case (ph_r)
				P_DEV: begin
					spec_r <= sh_r[7:4] == DT_SPECIAL; // RULE1 RULE6
					rd_r   <= sh_r[0];
					ph_r   <= sh_r[0] ? P_DATA : P_AHI;
				end
				P_AHI:   ph_r <= P_ALO;
				P_ALO:   ph_r <= P_DATA;
				default: ph_r <= ph_r;
			endcase
		end
	end

	// one pointer for every area; it survives between transfers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= '0;
		end else if (rx_done && byte_ack && ph_r == P_AHI) begin
			ptr_r[ADDR_W-1:BYTE_W] <= sh_r[ADDR_W-BYTE_W-1:0]; // RULE2 RULE10
		end else if (rx_done && byte_ack && ph_r == P_ALO) begin
			ptr_r[BYTE_W-1:0] <= sh_r;
		end else if (wr_ev) begin
			ptr_r <= wr_inc;
		end else if (load_ev) begin
			ptr_r <= rd_inc; // RULE8 RULE12
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_ev && !spec_r) begin
			main_mem[ptr_r] <= sh_r;
		end
		if (wr_ev && spec_r && region == REGION_ID) begin
			id_mem[ptr_r[ID_OFS_W-1:0]] <= sh_r;
		end
	end

	// the lock has no undo; only reset clears it in this model
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			locked_r <= 1'b0;
		end else if (wr_ev && spec_r && ptr_r[LOCK_POS] && sh_r[LOCK_DATA_POS]) begin
			locked_r <= 1'b1;
		end
	end

	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = oe_r;
	assign id_locked_o    = locked_r;
endmodule : idsn_dev

/* File: src/idsn_host.sv */
module idsn_host
	import idsn_pkg::*;
#(
	parameter int QTR   = SCL_QTR_CYC,
	parameter int DEPTH = 2
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	idsn_if.host             bus,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire idsn_op_t    cmd_op_i,
	input  wire logic [2:0]  cmd_dev_i,
	input  wire logic [15:0] cmd_addr_i,
	input  wire logic [7:0]  cmd_len_i,
	input  wire logic [7:0]  cmd_wdata_i,
	output logic             rd_valid_o,
	input  wire logic        rd_ready_i,
	output logic [7:0]       rd_data_o,
	output logic             done_o,
	output logic             nack_o
);
	typedef enum logic [9:0] {
		H_IDLE  = 10'h001,
		H_START = 10'h002,
		H_DEVW  = 10'h004,
		H_AHI   = 10'h008,
		H_ALO   = 10'h010,
		H_WDAT  = 10'h020,
		H_RST   = 10'h040,
		H_DEVR  = 10'h080,
		H_RD    = 10'h100,
		H_STOP  = 10'h200
	} idsn_hst_t;

	idsn_hst_t   st_r;
	idsn_op_t    op_r;
	logic [7:0]  qc_r;
	logic [1:0]  q_r;
	logic [3:0]  bn_r;
	logic [8:0]  rx_r;
	logic [2:0]  s_r;
	logic        sda_f_r;
	logic        scl_r;
	logic        oe_r;
	logic [2:0]  dev_r;
	logic [15:0] addr_r;
	logic [7:0]  left_r;
	logic [7:0]  wd_r;
	logic        nack_r;
	logic        done_r;
	logic        tick;
	logic        is_byte;
	logic        sym_end;
	logic        stall;
	logic        in_ready;
	logic        ack_ok;
	logic        spec;
	logic [7:0]  tx_byte;
	logic [8:0]  tx9;
	logic        scl_lv;
	logic        sda_lv;
	logic [15:0] c_addr;
	logic [7:0]  c_len;
	logic [7:0]  room;

	assign tick    = qc_r == 8'(QTR-1);
	assign is_byte = ~(st_r inside {H_IDLE, H_START, H_RST, H_STOP});
	assign sym_end = tick & (q_r == 2'h3) & (bn_r == (is_byte ? BYTE_BITS : 4'h0));
	// a read byte waits at its first quarter, scl held low, until the buffer has room
	assign stall   = (st_r == H_RD) & (bn_r == 4'h0) & (q_r == 2'h0) & ~in_ready;
	assign ack_ok  = ~rx_r[0];
	assign spec    = ~(op_r inside {OP_MAIN_READ, OP_CUR_MAIN}); // RULE1 RULE6
	assign room    = 8'(ID_BYTES) - {3'h0, cmd_addr_i[ID_OFS_W-1:0]};

	always_comb begin
		c_addr = cmd_addr_i;
		c_len  = (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
		case (cmd_op_i)
			OP_ID_READ: begin
				c_addr = cmd_addr_i & ID_OFS_MASK; // RULE2
				if (c_len > room) c_len = room; // RULE3
			end
			// the lock bit passes so that the same write can carry the lock command
			OP_PROBE:   c_addr = cmd_addr_i & (ID_OFS_MASK | (16'h0001 << LOCK_POS)); // RULE4
			OP_SN_READ: begin
				c_addr = SN_START_ADDR; // RULE9 RULE10
				c_len  = 8'(SN_BYTES); // RULE7
			end
			default:    c_addr = cmd_addr_i;
		endcase
	end

	always_comb begin
		case (st_r)
			H_DEVW:  tx_byte = {spec ? DT_SPECIAL : DT_MAIN, dev_r, 1'b0};
			H_DEVR:  tx_byte = {spec ? DT_SPECIAL : DT_MAIN, dev_r, 1'b1};
			H_AHI:   tx_byte = addr_r[15:8];
			H_ALO:   tx_byte = addr_r[7:0];
			H_WDAT:  tx_byte = wd_r;
			default: tx_byte = UNDEF_BYTE;
		endcase
		tx9 = (st_r == H_RD) ? {UNDEF_BYTE, left_r == 8'h01} : {tx_byte, 1'b1}; // RULE11
		scl_lv = (q_r == 2'h1) | (q_r == 2'h2);
		sda_lv = tx9[BYTE_BITS - bn_r];
		case (st_r)
			H_IDLE: begin
				scl_lv = 1'b1;
				sda_lv = 1'b1;
			end
			H_START, H_RST: sda_lv = ~q_r[1];
			H_STOP: begin
				scl_lv = q_r != 2'h0;
				sda_lv = q_r[1]; // RULE11
			end
			default: sda_lv = tx9[BYTE_BITS - bn_r];
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r     <= 3'h7;
			sda_f_r <= 1'b1;
			scl_r   <= 1'b1;
			oe_r    <= 1'b0;
		end else begin
			s_r     <= {s_r[1:0], bus.sda};
			sda_f_r <= (s_r[1] == s_r[2]) ? s_r[2] : sda_f_r;
			scl_r   <= scl_lv;
			oe_r    <= ~sda_lv;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			qc_r <= '0;
			q_r  <= '0;
			bn_r <= '0;
			rx_r <= '0;
		end else if (st_r == H_IDLE || stall) begin
			qc_r <= '0;
			q_r  <= '0;
			bn_r <= '0;
		end else if (tick) begin
			qc_r <= '0;
			q_r  <= q_r + 1'b1;
			if (q_r == 2'h2) rx_r <= {rx_r[7:0], sda_f_r};
			if (q_r == 2'h3) bn_r <= sym_end ? 4'h0 : bn_r + 1'b1;
		end else begin
			qc_r <= qc_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r   <= H_IDLE;
			op_r   <= OP_MAIN_READ;
			dev_r  <= '0;
			addr_r <= '0;
			left_r <= '0;
			wd_r   <= '0;
			nack_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (st_r == H_IDLE && cmd_valid_i) begin
				st_r   <= H_START;
				op_r   <= cmd_op_i;
				dev_r  <= cmd_dev_i;
				addr_r <= c_addr;
				left_r <= c_len;
				wd_r   <= cmd_wdata_i;
				nack_r <= 1'b0;
			end else if (sym_end) begin
				case (st_r)
					H_START: st_r <= (op_r inside {OP_CUR_MAIN, OP_CUR_SPEC}) ? H_DEVR : H_DEVW;
					H_DEVW, H_AHI, H_DEVR: begin
						nack_r <= ~ack_ok;
						if (!ack_ok) st_r <= H_STOP;
						else if (st_r == H_DEVW) st_r <= H_AHI;
						else if (st_r == H_AHI) st_r <= H_ALO;
						else st_r <= H_RD;
					end
					H_ALO: begin
						nack_r <= ~ack_ok;
						st_r   <= !ack_ok ? H_STOP : (op_r == OP_PROBE) ? H_WDAT : H_RST; // RULE6
					end
					H_WDAT: begin
						nack_r <= ~ack_ok; // RULE4
						st_r   <= H_STOP;
					end
					H_RST:  st_r <= H_DEVR;
					H_RD: begin
						left_r <= left_r - 8'h01;
						if (left_r == 8'h01) st_r <= H_STOP; // RULE11
					end
					H_STOP: begin
						st_r   <= H_IDLE;
						done_r <= 1'b1;
					end
					default: st_r <= H_IDLE;
				endcase
			end
		end
	end

	idsn_buf2 #(
		.W     (BYTE_W),
		.DEPTH (DEPTH)
	) u_buf (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  ((st_r == H_RD) & sym_end),
		.in_ready_o  (in_ready),
		.in_data_i   (rx_r[8:1]),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	assign cmd_ready_o     = st_r == H_IDLE;
	assign bus.scl         = scl_r;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = oe_r;
	assign done_o          = done_r;
	assign nack_o          = nack_r;
endmodule : idsn_host
